// ===== nps_byte_ram.sv
/*
 * 256 x 8 message buffer with one write port and one registered read port.
 * Assumes a single clock; read data follow the read address by one edge.
 */
`timescale 1ns/1ps
module nps_byte_ram (
    input  wire logic       pclk,    // Clock
    input  wire logic       presetn, // Async reset, active low
    input  wire logic       we,      // Write strobe
    input  wire logic [7:0] waddr,   // Write address
    input  wire logic [7:0] wdata,   // Write data
    input  wire logic [7:0] raddr,   // Read address
    output logic      [7:0] rdata    // Registered read data
);
    logic [7:0] mem [0:255];

    ////////////////////////////////////////////////////////////////////////
    // Array without reset so it maps onto block memory
    always_ff @(posedge pclk) begin
        if (we) begin
            mem[waddr] <= wdata;
        end
    end

    // Read register, cleared only so the output is defined from reset
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rdata <= 8'h00;
        end else begin
            rdata <= mem[raddr];
        end
    end
endmodule // nps_byte_ram

// ===== nps_defs.svh
/*
 * Offsets, field positions, reset values and timing counts of the serial framer.
 * Assumes inclusion by bare name from the framer top; definitions only.
 */
`ifndef NPS_DEFS_SVH
`define NPS_DEFS_SVH

// Register byte offsets
`define NPS_OFS_CTRL        12'h000
`define NPS_OFS_CODES       12'h004
`define NPS_OFS_DELAY       12'h008
`define NPS_OFS_TXCMD       12'h00C
`define NPS_OFS_RXCMD       12'h010
// Buffer windows, one byte per aligned word, selected by paddr[11:10]
`define NPS_WIN_TXBUF       2'h1
`define NPS_WIN_RXBUF       2'h2

// Field positions
`define NPS_CTRL_START_EN   0
`define NPS_CTRL_END_LO     1
`define NPS_CTRL_END_HI     2
`define NPS_ST_TX_BUSY      0
`define NPS_ST_TX_LENERR    1
`define NPS_ST_RX_BUSY      0
`define NPS_ST_RX_DONE      1
`define NPS_ST_RX_OVF       2
`define NPS_ST_RX_CNT_LO    8
`define NPS_ST_RX_CNT_HI    16

// Reset values
`define NPS_RST_START_CODE  8'h02
`define NPS_RST_END_CODE    8'h03
`define NPS_RST_DELAY       14'h0000

// Frame limits and fixed terminator bytes
`define NPS_MAX_MSG         9'd256
`define NPS_CHAR_CR         8'h0D
`define NPS_CHAR_LF         8'h0A

// Send delay: unit and range as printed, cycles derived from the clock rate
`define NPS_CLK_HZ          40000000
`define NPS_DELAY_UNIT_MS   10
`define NPS_DELAY_MAX_MS    99990
`define NPS_DELAY_MAX_UNITS (`NPS_DELAY_MAX_MS / `NPS_DELAY_UNIT_MS)
`define NPS_UNIT_CYCLES     ((`NPS_CLK_HZ / 1000) * `NPS_DELAY_UNIT_MS)

`endif

// ===== nps_ext_dev.sv
/* Far-side serial device: takes sent bytes, offers queued bytes.
   Assumes the bench fills pend, reads got and sets stall by hierarchy. */
`timescale 1ns/1ps
module nps_ext_dev (
    input  wire logic       pclk,     // Clock
    input  wire logic       presetn,  // Reset, active low
    input  wire logic [7:0] tx_data,  // Byte from framer
    input  wire logic       tx_valid, // Byte offered
    output logic            tx_ready, // Byte taken
    output logic      [7:0] rx_data,  // Byte to framer
    output logic            rx_valid, // Byte offered
    input  wire logic       rx_ready  // Byte taken
);
    logic [7:0] got[$];       // Bytes taken
    logic [7:0] pend[$];      // Bytes to offer
    logic       stall = 1'b0; // Slow take side
    ////////////////////////////////////////////////////////////////
    // Take side: every other cycle while stalled
    always @(posedge pclk or negedge presetn)
        if (!presetn) tx_ready <= 1'b0;
        else begin
            if (tx_valid && tx_ready) got.push_back(tx_data);
            tx_ready <= !stall || !tx_ready;
        end
    // Offer side: held until taken; a released line shows the inverted last byte
    always @(posedge pclk or negedge presetn)
        if (!presetn) {rx_valid, rx_data} <= 9'h000;
        else if (rx_valid && rx_ready) {rx_valid, rx_data} <= {1'b0, ~rx_data};
        else if (!rx_valid && pend.size() > 0) {rx_valid, rx_data} <= {1'b1, pend.pop_front()};
endmodule // nps_ext_dev

// ===== nps_framer.sv
/*
 * No-protocol serial framer: APB registers, send path with delay and delimiters,
 * receive path that strips delimiters into a buffer.
 * Assumes byte-wide tx/rx streams from serializer logic on the same pclk.
 */
`timescale 1ns/1ps
`include "nps_defs.svh"

module nps_framer import nps_pkg::*; #(
    parameter int unsigned TICK_CYCLES = `NPS_UNIT_CYCLES // Cycles per 10 ms delay step
) (
    input  wire logic        pclk,     // APB clock, 40 MHz
    input  wire logic        presetn,  // Async reset, active low
    input  wire logic        psel,     // APB select
    input  wire logic        penable,  // APB access phase
    input  wire logic        pwrite,   // APB direction
    input  wire logic [11:0] paddr,    // APB byte address
    input  wire logic [31:0] pwdata,   // APB write data
    output logic      [31:0] prdata,   // APB read data
    output logic             pready,   // APB ready
    output logic             pslverr,  // APB error on unmapped address
    output logic      [7:0]  tx_data,  // Byte to serializer
    output logic             tx_valid, // Byte offered
    input  wire logic        tx_ready, // Serializer takes byte
    input  wire logic [7:0]  rx_data,  // Byte from deserializer
    input  wire logic        rx_valid, // Byte offered
    output logic             rx_ready  // Framer takes byte
);
    nps_state_t s_reg;
    nps_state_t s_next;
    logic [7:0] txm_rdata;
    logic [7:0] rxm_rdata;
    logic       rxm_we;
    logic [7:0] rxm_wdata;
    logic       txm_we;
    logic       acc_done;
    logic       wr_do;
    logic       rx_fire;
    logic [8:0] maxp;
    logic [8:0] len_in;
    logic [13:0] dly_in;

    ////////////////////////////////////////////////////////////////////////
    // Payload limit for a delimiter set
    function automatic logic [8:0] max_payload(input logic st_en, input logic [1:0] mode);
        logic [8:0] n;
        n = `NPS_MAX_MSG;
        if (st_en) begin
            n = n - 9'd1;
        end
        if (mode == NPS_END_BYTE) begin
            n = n - 9'd1;
        end else if (mode == NPS_END_CRLF) begin
            n = n - 9'd2;
        end
        return n;
    endfunction

    // Register offset match within the register page
    function automatic logic reg_hit(input logic [11:0] a, input logic [11:0] ofs);
        return a == ofs;
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // Buffers: software fills the send buffer, receiver fills the other
    nps_byte_ram u_txbuf (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (txm_we),
        .waddr   (paddr[9:2]),
        .wdata   (pwdata[7:0]),
        .raddr   (s_reg.tx_idx[7:0]),
        .rdata   (txm_rdata)
    );

    nps_byte_ram u_rxbuf (
        .pclk    (pclk),
        .presetn (presetn),
        .we      (rxm_we),
        .waddr   (s_reg.rx_cnt[7:0]),
        .wdata   (rxm_wdata),
        .raddr   (paddr[9:2]),
        .rdata   (rxm_rdata)
    );

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle so buffer reads come from a register
    assign acc_done = psel & penable & s_reg.acc_wait;
    assign wr_do    = acc_done & pwrite;
    assign pready   = acc_done;
    assign prdata   = s_reg.prdata;
    assign pslverr  = s_reg.pslverr & acc_done;
    assign txm_we   = wr_do & (paddr[11:10] == `NPS_WIN_TXBUF);
    assign maxp     = max_payload(s_reg.start_en, s_reg.end_mode);
    assign len_in   = pwdata[8:0];
    assign dly_in   = pwdata[13:0];

    // Stream handshake outputs
    assign tx_data  = s_reg.tx_byte;
    assign tx_valid = s_reg.have;
    assign rx_fire  = rx_valid & rx_ready;

    // Receiver ready; after CR a non-LF byte waits while the CR is stored
    always_comb begin
        case (s_reg.rx_st)
            NPS_RX_HUNT:   rx_ready = 1'b1;
            NPS_RX_DATA:   rx_ready = 1'b1;
            NPS_RX_CRSEEN: rx_ready = rx_valid & (rx_data == `NPS_CHAR_LF);
            default:       rx_ready = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // Next state of the whole block
    always_comb begin
        s_next    = s_reg;
        rxm_we    = 1'b0;
        rxm_wdata = rx_data;

        // Bus phase tracking and read data capture in the first access cycle
        s_next.acc_wait = psel & penable & ~s_reg.acc_wait;
        if (psel & penable & ~s_reg.acc_wait) begin
            s_next.prdata  = 32'h0000_0000;
            s_next.pslverr = 1'b0;
            if (paddr[11:10] == `NPS_WIN_TXBUF) begin
                s_next.pslverr = 1'b0;
            end else if (paddr[11:10] == `NPS_WIN_RXBUF) begin
                s_next.prdata = {24'h00_0000, rxm_rdata};
            end else if (reg_hit(paddr, `NPS_OFS_CTRL)) begin
                s_next.prdata = {29'h0000_0000, s_reg.end_mode, s_reg.start_en};
            end else if (reg_hit(paddr, `NPS_OFS_CODES)) begin
                s_next.prdata = {16'h0000, s_reg.end_code, s_reg.start_code};
            end else if (reg_hit(paddr, `NPS_OFS_DELAY)) begin
                s_next.prdata = {18'h0_0000, s_reg.delay_units};
            end else if (reg_hit(paddr, `NPS_OFS_TXCMD)) begin
                s_next.prdata = {30'h0000_0000, s_reg.len_err, s_reg.tx_st != NPS_TX_IDLE};
            end else if (reg_hit(paddr, `NPS_OFS_RXCMD)) begin
                s_next.prdata = {15'h0000, s_reg.rx_cnt, 5'h00, s_reg.rx_ovf, s_reg.rx_done,
                                 s_reg.rx_st != NPS_RX_IDLE};
            end else begin
                s_next.pslverr = 1'b1;
            end
        end

        // Configuration writes; delay clamps to its top step
        if (wr_do & reg_hit(paddr, `NPS_OFS_CTRL)) begin
            s_next.start_en = pwdata[`NPS_CTRL_START_EN];
            s_next.end_mode = pwdata[`NPS_CTRL_END_HI:`NPS_CTRL_END_LO];
        end
        if (wr_do & reg_hit(paddr, `NPS_OFS_CODES)) begin
            s_next.start_code = pwdata[7:0];
            s_next.end_code   = pwdata[15:8];
        end
        if (wr_do & reg_hit(paddr, `NPS_OFS_DELAY)) begin
            s_next.delay_units = (dly_in > 14'(`NPS_DELAY_MAX_UNITS)) ?
                                 14'(`NPS_DELAY_MAX_UNITS) : dly_in;
        end

        // Send path
        case (s_reg.tx_st)
            NPS_TX_IDLE: begin
                if (wr_do & reg_hit(paddr, `NPS_OFS_TXCMD)) begin
                    // Over-long or empty requests are refused, not truncated
                    if ((len_in == 9'd0) || (len_in > maxp)) begin
                        s_next.len_err = 1'b1;
                    end else begin
                        s_next.len_err = 1'b0;
                        s_next.tx_len  = len_in;
                        s_next.tx_idx  = 9'd0;
                        s_next.dly_cnt = s_reg.delay_units;
                        s_next.presc   = 19'd0;
                        s_next.tx_st   = NPS_TX_DELAY;
                    end
                end
            end
            NPS_TX_DELAY: begin
                if (s_reg.dly_cnt == 14'd0) begin
                    s_next.data_ok = 1'b0;
                    if (s_reg.start_en) begin
                        s_next.tx_byte = s_reg.start_code;
                        s_next.have    = 1'b1;
                        s_next.tx_st   = NPS_TX_START;
                    end else begin
                        s_next.tx_st = NPS_TX_DATA;
                    end
                end else if (s_reg.presc == 19'(TICK_CYCLES - 1)) begin
                    s_next.presc   = 19'd0;
                    s_next.dly_cnt = s_reg.dly_cnt - 14'd1;
                end else begin
                    s_next.presc = s_reg.presc + 19'd1;
                end
            end
            NPS_TX_START: begin
                if (s_reg.have & tx_ready) begin
                    s_next.have  = 1'b0;
                    s_next.tx_st = NPS_TX_DATA;
                end
            end
            NPS_TX_DATA: begin
                // Buffer read data lag the index by one edge
                s_next.data_ok = 1'b1;
                if (~s_reg.have & s_reg.data_ok) begin
                    s_next.tx_byte = txm_rdata;
                    s_next.have    = 1'b1;
                end
                if (s_reg.have & tx_ready) begin
                    s_next.have    = 1'b0;
                    s_next.data_ok = 1'b0;
                    s_next.tx_idx  = s_reg.tx_idx + 9'd1;
                    if (s_reg.tx_idx + 9'd1 == s_reg.tx_len) begin
                        if (s_reg.end_mode == NPS_END_BYTE) begin
                            s_next.tx_byte = s_reg.end_code;
                            s_next.have    = 1'b1;
                            s_next.tx_st   = NPS_TX_END1;
                        end else if (s_reg.end_mode == NPS_END_CRLF) begin
                            s_next.tx_byte = `NPS_CHAR_CR;
                            s_next.have    = 1'b1;
                            s_next.tx_st   = NPS_TX_END1;
                        end else begin
                            s_next.tx_st = NPS_TX_IDLE;
                        end
                    end
                end
            end
            NPS_TX_END1: begin
                if (s_reg.have & tx_ready) begin
                    if (s_reg.end_mode == NPS_END_CRLF) begin
                        s_next.tx_byte = `NPS_CHAR_LF;
                        s_next.tx_st   = NPS_TX_END2;
                    end else begin
                        s_next.have  = 1'b0;
                        s_next.tx_st = NPS_TX_IDLE;
                    end
                end
            end
            NPS_TX_END2: begin
                if (s_reg.have & tx_ready) begin
                    s_next.have  = 1'b0;
                    s_next.tx_st = NPS_TX_IDLE;
                end
            end
            default: begin
                s_next.have  = 1'b0;
                s_next.tx_st = NPS_TX_IDLE;
            end
        endcase

        // Receive path; arming is honoured only while idle
        case (s_reg.rx_st)
            NPS_RX_IDLE: begin
                if (wr_do & reg_hit(paddr, `NPS_OFS_RXCMD) & pwdata[0]) begin
                    s_next.rx_cnt  = 9'd0;
                    s_next.rx_done = 1'b0;
                    s_next.rx_ovf  = 1'b0;
                    s_next.rx_st   = s_reg.start_en ? NPS_RX_HUNT : NPS_RX_DATA;
                end
            end
            NPS_RX_HUNT: begin
                // Anything before the first start code is dropped
                if (rx_fire & (rx_data == s_reg.start_code)) begin
                    s_next.rx_st = NPS_RX_DATA;
                end
            end
            NPS_RX_DATA: begin
                if (rx_fire) begin
                    if ((s_reg.end_mode == NPS_END_BYTE) & (rx_data == s_reg.end_code)) begin
                        s_next.rx_done = 1'b1;
                        s_next.rx_st   = NPS_RX_IDLE;
                    end else if ((s_reg.end_mode == NPS_END_CRLF) & (rx_data == `NPS_CHAR_CR)) begin
                        s_next.rx_st = NPS_RX_CRSEEN;
                    end else begin
                        rxm_we        = 1'b1;
                        s_next.rx_cnt = s_reg.rx_cnt + 9'd1;
                        if (s_reg.rx_cnt + 9'd1 == maxp) begin
                            // Limit reached: normal end without end code, overflow otherwise
                            s_next.rx_done = 1'b1;
                            s_next.rx_ovf  = s_reg.end_mode == NPS_END_BYTE ||
                                             s_reg.end_mode == NPS_END_CRLF;
                            s_next.rx_st   = NPS_RX_IDLE;
                        end
                    end
                end
            end
            NPS_RX_CRSEEN: begin
                if (rx_fire) begin
                    s_next.rx_done = 1'b1;
                    s_next.rx_st   = NPS_RX_IDLE;
                end else if (rx_valid) begin
                    // Lone CR is payload; the held byte is taken next cycle unless the CR reaches the limit
                    rxm_we        = 1'b1;
                    rxm_wdata     = `NPS_CHAR_CR;
                    s_next.rx_cnt = s_reg.rx_cnt + 9'd1;
                    s_next.rx_st  = NPS_RX_DATA;
                    if (s_reg.rx_cnt + 9'd1 == maxp) begin
                        s_next.rx_done = 1'b1;
                        s_next.rx_ovf  = 1'b1;
                        s_next.rx_st   = NPS_RX_IDLE;
                    end
                end
            end
            default: begin
                s_next.rx_st = NPS_RX_IDLE;
            end
        endcase
    end

    ////////////////////////////////////////////////////////////////////////
    // State register
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_reg             <= '0;
            s_reg.tx_st       <= NPS_TX_IDLE;
            s_reg.rx_st       <= NPS_RX_IDLE;
            s_reg.end_mode    <= NPS_END_NONE;
            s_reg.start_code  <= `NPS_RST_START_CODE;
            s_reg.end_code    <= `NPS_RST_END_CODE;
            s_reg.delay_units <= `NPS_RST_DELAY;
        end else begin
            s_reg <= s_next;
        end
    end
endmodule // nps_framer

// ===== nps_framer_asserts.sv
/* Port checker of the serial framer: APB timing, send stream holding, message length.
   Assumes binding into nps_framer and a master that holds each request until pready. */
`timescale 1ns/1ps
`include "nps_defs.svh"
module nps_framer_asserts (
    input wire logic        pclk,     // Clock
    input wire logic        presetn,  // Reset, active low
    input wire logic        psel,     // Select
    input wire logic        penable,  // Access phase
    input wire logic        pwrite,   // Direction
    input wire logic [11:0] paddr,    // Address
    input wire logic [31:0] prdata,   // Read data
    input wire logic        pready,   // Ready
    input wire logic        pslverr,  // Error
    input wire logic [7:0]  tx_data,  // Sent byte
    input wire logic        tx_valid, // Byte offered
    input wire logic        tx_ready  // Byte taken
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    logic       cmd_wr;   // Send command accepted
    logic [9:0] sent_cnt; // Bytes sent since then
    assign cmd_wr = psel && penable && pready && pwrite && paddr == `NPS_OFS_TXCMD;
    // Restarts per command so each message is judged on its own
    always_ff @(posedge pclk or negedge presetn)
        if (!presetn) sent_cnt <= 10'h000;
        else if (cmd_wr) sent_cnt <= 10'h000;
        else if (tx_valid && tx_ready) sent_cnt <= sent_cnt + 10'h001;
    ////////////////////////////////////////////////////////////////
    sequence s_setup; psel && !penable; endsequence
    sequence s_acc(rdy); psel && penable && pready == rdy; endsequence
    a_one_wait: assert property (s_setup |=> s_acc(1'b0) ##1 s_acc(1'b1))
        else $error("Ready not in the second access cycle");
    a_ready_once: assert property (pready |=> !pready)
        else $error("Ready held past one cycle");
    a_ready_sel: assert property (pready |-> psel && penable)
        else $error("Ready outside an access");
    a_err_ready: assert property (pslverr |-> pready)
        else $error("Error without ready");
    a_err_rdzero: assert property (pslverr && !pwrite |-> prdata == 32'h0000_0000)
        else $error("Refused read returned data");
    a_tx_hold: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
        else $error("Offered byte dropped or changed");
    a_msg_limit: assert property (sent_cnt <= 10'h100)
        else $error("Message longer than 256 bytes");
    a_send_quiet: assert property (cmd_wr && !tx_valid |=> !tx_valid)
        else $error("Byte sent too soon after command");
endmodule // nps_framer_asserts
bind nps_framer nps_framer_asserts nps_framer_asserts_inst (.pclk, .presetn, .psel, .penable, .pwrite,
    .paddr, .prdata, .pready, .pslverr, .tx_data, .tx_valid, .tx_ready);

// ===== nps_pkg.sv
/*
 * Types of the serial framer: end code mode, both state machines and the state record.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package nps_pkg;

    typedef enum logic [1:0] {
        NPS_END_NONE = 2'h0,
        NPS_END_BYTE = 2'h1,
        NPS_END_CRLF = 2'h2
    } nps_end_t;

    // Gray codes along IDLE > DELAY > START > DATA > END1 > END2
    typedef enum logic [2:0] {
        NPS_TX_IDLE  = 3'h0,
        NPS_TX_DELAY = 3'h1,
        NPS_TX_START = 3'h3,
        NPS_TX_DATA  = 3'h2,
        NPS_TX_END1  = 3'h6,
        NPS_TX_END2  = 3'h7
    } nps_tx_t;

    // Gray codes along IDLE > HUNT > DATA > CRSEEN
    typedef enum logic [1:0] {
        NPS_RX_IDLE   = 2'h0,
        NPS_RX_HUNT   = 2'h1,
        NPS_RX_DATA   = 2'h3,
        NPS_RX_CRSEEN = 2'h2
    } nps_rx_t;

    typedef struct packed {
        nps_tx_t     tx_st;
        nps_rx_t     rx_st;
        logic        start_en;
        logic [1:0]  end_mode;
        logic [7:0]  start_code;
        logic [7:0]  end_code;
        logic [13:0] delay_units;
        logic [13:0] dly_cnt;
        logic [18:0] presc;
        logic [8:0]  tx_len;
        logic [8:0]  tx_idx;
        logic        data_ok;
        logic        have;
        logic [7:0]  tx_byte;
        logic        len_err;
        logic [8:0]  rx_cnt;
        logic        rx_done;
        logic        rx_ovf;
        logic        acc_wait;
        logic [31:0] prdata;
        logic        pslverr;
    } nps_state_t;

endpackage

// ===== tb.sv
/* Self-checking bench of the serial framer: registers, send frames and delay, receive frames.
   Assumes nps_ext_dev on the byte streams and the bound port checker. */
`timescale 1ns/1ps
`include "nps_defs.svh"
`define CHK(nm, ex, gt) begin checks_done++; if ((gt) !== (ex)) begin n_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", nm, ex, gt); end end
module tb;
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, re;
    logic        tx_valid, tx_ready, rx_valid, rx_ready;
    logic [7:0]  tx_data, rx_data;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rq;
    logic [7:0]  q[$];
    int          n_errors = 0, checks_done = 0;
    // Short delay step keeps the send delay case brief
    nps_framer #(.TICK_CYCLES(4)) nps_framer_inst (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid, .rx_ready);
    nps_ext_dev nps_ext_dev_inst (.pclk, .presetn, .tx_data, .tx_valid, .tx_ready, .rx_data, .rx_valid,
        .rx_ready);
    // Clock and watchdog, the latter far beyond the expected run
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    initial begin
        #(25 * 60000);
        n_errors++;
        conclude();
    end
    ////////////////////////////////////////////////////////////////
    task automatic conclude;
        if (n_errors == 0 && checks_done > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    // One APB transfer; request held until pready, answer taken at that edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge pclk);
        {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
        rq = prdata;
        re = pslverr;
        {psel, penable} <= 2'h0;
        if (n >= 20) n_errors++;
    endtask
    // Poll a status bit under a bound
    task automatic poll(input logic [11:0] a, input int b, input logic v);
        int n = 0;
        do apb(1'b0, a, 32'h0); while (rq[b] !== v && ++n < 3000);
        if (n >= 3000) n_errors++;
    endtask
    task automatic cfg(input logic s, input logic [1:0] m, input logic [7:0] st, input logic [7:0] ed);
        apb(1'b1, `NPS_OFS_CTRL, {29'h0, m, s});
        apb(1'b1, `NPS_OFS_CODES, {16'h0, ed, st});
    endtask
    ////////////////////////////////////////////////////////////////
    // Reset values, delay clamp, unmapped places, then a counting pattern in the send buffer
    task automatic t_regs;
        apb(1'b0, `NPS_OFS_CODES, 32'h0);
        `CHK("codes", 32'h0000_0302, rq)
        apb(1'b0, `NPS_OFS_CTRL, 32'h0);
        `CHK("ctrl", 32'h0000_0000, rq)
        apb(1'b1, `NPS_OFS_DELAY, 32'h0000_3FFF);
        apb(1'b0, `NPS_OFS_DELAY, 32'h0);
        `CHK("delay_clamp", 32'h0000_270F, rq)
        apb(1'b0, 12'h0FC, 32'h0);
        `CHK("unmapped_rd", {1'b1, 32'h0}, {re, rq})
        apb(1'b1, 12'hC00, 32'hFFFF_FFFF);
        `CHK("unmapped_wr", 1'b1, re)
        apb(1'b1, `NPS_OFS_DELAY, 32'h0);
        for (int i = 0; i < 256; i++) apb(1'b1, 12'h400 + 12'(i * 4), 32'(i));
    endtask
    // Full 256-byte message in one delimiter mode, after a refused over-long command
    task automatic tx_case(input logic s, input logic [1:0] m);
        logic [7:0] ex[$];
        int lim = 256 - s - (m == 2'h2 ? 2 : m);
        cfg(s, m, 8'hA5, 8'h5A);
        if (s) ex.push_back(8'hA5);
        for (int i = 0; i < lim; i++) ex.push_back(i[7:0]);
        if (m == 2'h1) ex.push_back(8'h5A);
        if (m == 2'h2) ex = {ex, 8'h0D, 8'h0A};
        nps_ext_dev_inst.got.delete();
        apb(1'b1, `NPS_OFS_TXCMD, 32'(lim + 1));
        poll(`NPS_OFS_TXCMD, 0, 1'b0);
        `CHK("len_err", 1'b1, rq[1])
        apb(1'b1, `NPS_OFS_TXCMD, 32'(lim));
        poll(`NPS_OFS_TXCMD, 0, 1'b0);
        `CHK("len_clr", 1'b0, rq[1])
        `CHK("msg_len", 32'(ex.size()), 32'(nps_ext_dev_inst.got.size()))
        foreach (ex[i]) `CHK("tx_byte", ex[i], nps_ext_dev_inst.got[i])
    endtask
    // First byte appears 2 cycles plus 3 delay steps after the command
    task automatic t_delay;
        int n = 0;
        nps_ext_dev_inst.stall = 1'b0;
        cfg(1'b1, 2'h0, 8'hA5, 8'h5A);
        apb(1'b1, `NPS_OFS_DELAY, 32'h0000_0003);
        apb(1'b1, `NPS_OFS_TXCMD, 32'h0000_0001);
        do begin
            @(posedge pclk);
            #1;
        end while (tx_valid !== 1'b1 && ++n < 100);
        `CHK("send_delay", 2 + 3 * 4, n + 2)
        poll(`NPS_OFS_TXCMD, 0, 1'b0);
        apb(1'b1, `NPS_OFS_DELAY, 32'h0);
    endtask
    // Arm, feed bytes, then check count and stored payload
    task automatic rx_case(input logic [7:0] in[$], input logic [7:0] ex[$]);
        apb(1'b1, `NPS_OFS_RXCMD, 32'h0000_0001);
        foreach (in[i]) nps_ext_dev_inst.pend.push_back(in[i]);
        poll(`NPS_OFS_RXCMD, 1, 1'b1);
        `CHK("rx_cnt", 9'(ex.size()), rq[16:8])
        `CHK("rx_ovf", 1'b0, rq[2])
        foreach (ex[i]) begin
            apb(1'b0, 12'h800 + 12'(i * 4), 32'h0);
            `CHK("rx_byte", ex[i], rq[7:0])
        end
    endtask
    ////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        nps_ext_dev_inst.stall = 1'b1;
        for (int k = 0; k < 6; k++) tx_case(k[0], k[2:1]);
        t_delay();
        cfg(1'b1, 2'h1, 8'h02, 8'h03);
        rx_case('{8'h55, 8'h02, 8'h41, 8'h02, 8'h03, 8'h03}, '{8'h41, 8'h02});
        cfg(1'b1, 2'h2, 8'h02, 8'h03);
        rx_case('{8'h0D, 8'h02, 8'h0D, 8'h41, 8'h0D, 8'h0A}, '{8'h0D, 8'h41});
        cfg(1'b0, 2'h0, 8'h02, 8'h03);
        for (int i = 0; i < 256; i++) q.push_back(i[7:0]);
        rx_case(q, q);
        conclude();
    end
endmodule // tb
